// >>> hw/event_timer_consts.svh
// Constants of the 16-bit event timer: offsets, bit positions, reset values, timing.
// Assumes inclusion by bare name from the package, ahead of the design modules.
`ifndef EVENT_TIMER_CONSTS_SVH
`define EVENT_TIMER_CONSTS_SVH

`define ET_ADDR_COUNT_LOW 2'h0
`define ET_ADDR_COUNT_HIGH 2'h1
`define ET_ADDR_COUNTER_CONTROL 2'h2
`define ET_ADDR_IRQ_CONTROL 2'h3

`define ET_CTRL_MODE_HI_BIT 7
`define ET_CTRL_MODE_LO_BIT 6
`define ET_CTRL_RUN_BIT 4
`define ET_CTRL_EDGE_BIT 3
`define ET_IRQ_ENABLE_BIT 0
`define ET_IRQ_FLAG_BIT 1

`define ET_CTRL_RESET 8'h00
`define ET_IRQ_RESET 8'h00
`define ET_COUNT_RESET 16'h0000
`define ET_COUNT_FULL 16'hFFFF

`define ET_SYS_PERIOD_NS 10
`define ET_INSTR_DIV 4

`endif

// >>> hw/event_timer_pkg.sv
// Types shared by the event timer design files.
// Assumes the constants header sits in the include path.
`include "event_timer_consts.svh"

package event_timer_pkg;

  typedef enum logic [1:0] {
    mode_hold_type_e = 2'h0,
    mode_event_e = 2'h1,
    mode_timer_e = 2'h2,
    mode_pulse_e = 2'h3
  } mode_type;

  // Pulse measurement phase, Gray coded along idle -> arm -> measure
  typedef enum logic [1:0] {
    pw_idle = 2'h0,
    pw_armed = 2'h1,
    pw_measure = 2'h3
  } pw_state_type;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic rise;
    logic fall;
    logic level;
  } pin_events_type;

endpackage

// >>> hw/pin_edge_sync.sv
// Two-flop synchroniser with edge detect for the external timer input.
// Assumes the pin is asynchronous to core_clk_i.
`timescale 1ns/1ps
`default_nettype none

module pin_edge_sync
  import event_timer_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Pin and events
  input wire logic pin_i,
  output pin_events_type events_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_state_type;

  sync_state_type state;
  sync_state_type next_state;

  always_comb begin
    next_state = state;
    next_state.meta = pin_i;
    next_state.sync = state.meta;
    next_state.prev = state.sync;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Edges only from the second and third stage; meta stays private
  assign events_o.rise = state.sync & ~state.prev;
  assign events_o.fall = ~state.sync & state.prev;
  assign events_o.level = state.sync;

endmodule

`default_nettype wire

// >>> hw/event_timer_16bit.sv
// 16-bit event timer: interval timer, event counter, pulse width measurement.
// Assumes a simple strobe register port on core_clk_i and an asynchronous timer pin.
`timescale 1ns/1ps
`default_nettype none

module event_timer_16bit
  import event_timer_pkg::*;
#(
  parameter int COUNT_WIDTH = 16,
  parameter int INSTR_DIV = `ET_INSTR_DIV
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Register port
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // External timer pin
  input wire logic timer_pin_i,
  // Interrupt request
  output logic irq_o
);

  localparam int DIV_W = $clog2(INSTR_DIV);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [COUNT_WIDTH-1:0] count;
    logic [COUNT_WIDTH-1:0] preload;
    logic [7:0] low_wbuf;
    logic [7:0] low_rlatch;
    logic [7:0] control;
    logic irq_enable;
    logic irq_flag;
    logic [DIV_W-1:0] div;
    pw_state_type pw;
    logic [7:0] rdata;
    logic irq;
  } timer_state_type;

  timer_state_type state;
  timer_state_type next_state;
  pin_events_type pin_ev;
  bus_req_type req;

  assign req.addr = addr_i;
  assign req.wdata = wdata_i;
  assign req.wr = wr_i;
  assign req.rd = rd_i;

  pin_edge_sync u_pin_sync (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .pin_i(timer_pin_i),
    .events_o(pin_ev)
  );

  ////////////////////////////////////////////////////////////////////////////

  mode_type mode;
  logic run_bit;
  logic edge_select;
  logic instr_tick;
  logic active_edge;
  logic idle_edge;
  logic tick;
  logic overflow;
  logic preload_commit;

  assign mode = mode_type'({state.control[`ET_CTRL_MODE_HI_BIT], state.control[`ET_CTRL_MODE_LO_BIT]});
  assign run_bit = state.control[`ET_CTRL_RUN_BIT];
  assign edge_select = state.control[`ET_CTRL_EDGE_BIT];
  assign instr_tick = (state.div == DIV_W'(INSTR_DIV - 1));
  // Pulse mode: active edge is falling for a low pulse, rising for a high one
  assign active_edge = edge_select ? pin_ev.rise : pin_ev.fall;
  assign idle_edge = edge_select ? pin_ev.fall : pin_ev.rise;
  assign preload_commit = req.wr && (req.addr == `ET_ADDR_COUNT_HIGH);

  always_comb begin
    tick = 1'b0;
    if (run_bit) begin
      unique case (mode)
        mode_timer_e: tick = instr_tick;
        mode_event_e: tick = edge_select ? pin_ev.fall : pin_ev.rise;
        mode_pulse_e: tick = instr_tick && (state.pw == pw_measure);
        mode_hold_type_e: tick = 1'b0;
      endcase
    end
  end

  assign overflow = tick && (state.count == `ET_COUNT_FULL);

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_state = state;
    next_state.div = instr_tick ? '0 : DIV_W'(state.div + 1'b1);

    // Counting; wraps past full into the preload value
    if (tick) begin
      next_state.count = overflow ? state.preload : COUNT_WIDTH'(state.count + 1'b1);
    end

    // Pulse measurement sequencing
    if (mode == mode_pulse_e && run_bit) begin
      unique case (state.pw)
        pw_idle: next_state.pw = pw_armed;
        pw_armed: if (active_edge) next_state.pw = pw_measure;
        pw_measure: begin
          if (idle_edge) begin
            // Run drops so later transitions are ignored until rearmed
            next_state.pw = pw_idle;
            next_state.control[`ET_CTRL_RUN_BIT] = 1'b0;
          end
        end
        default: next_state.pw = pw_idle;
      endcase
    end else begin
      next_state.pw = pw_idle;
    end

    // Register writes
    if (req.wr) begin
      unique case (req.addr)
        `ET_ADDR_COUNT_LOW: next_state.low_wbuf = req.wdata;
        `ET_ADDR_COUNT_HIGH: begin
          next_state.preload = {req.wdata, state.low_wbuf};
        end
        `ET_ADDR_COUNTER_CONTROL: begin
          next_state.control = req.wdata;
          // Software rewrite restarts a pulse measurement from the idle state
          next_state.pw = pw_idle;
        end
        `ET_ADDR_IRQ_CONTROL: begin
          next_state.irq_enable = req.wdata[`ET_IRQ_ENABLE_BIT];
          // Writing one clears the flag
          if (req.wdata[`ET_IRQ_FLAG_BIT]) next_state.irq_flag = 1'b0;
        end
      endcase
    end

    // Preload moves straight in only while stopped
    if (preload_commit && !run_bit) begin
      next_state.count = {req.wdata, state.low_wbuf};
    end

    // Overflow sets the flag; set wins over a same-cycle clear
    if (overflow) next_state.irq_flag = 1'b1;

    // Register reads, data valid one cycle later
    next_state.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `ET_ADDR_COUNT_LOW: next_state.rdata = state.low_rlatch;
        `ET_ADDR_COUNT_HIGH: begin
          next_state.rdata = state.count[15:8];
          next_state.low_rlatch = state.count[7:0];
        end
        `ET_ADDR_COUNTER_CONTROL: next_state.rdata = state.control;
        `ET_ADDR_IRQ_CONTROL: begin
          next_state.rdata = 8'h00;
          next_state.rdata[`ET_IRQ_ENABLE_BIT] = state.irq_enable;
          next_state.rdata[`ET_IRQ_FLAG_BIT] = state.irq_flag;
        end
      endcase
    end

    // Request gated by enable; flag stays visible either way
    next_state.irq = next_state.irq_flag && next_state.irq_enable;
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= '0;
      state.control <= `ET_CTRL_RESET;
      state.count <= `ET_COUNT_RESET;
      state.preload <= `ET_COUNT_RESET;
      state.pw <= pw_idle;
    end else begin
      state <= next_state;
    end
  end

  assign rdata_o = state.rdata;
  assign irq_o = state.irq;

endmodule

`default_nettype wire

// >>> test/pin_source.sv
// Model of the pulse source on the external timer pin.
// Assumes one go_i cycle starts one pulse of width_i cycles away from idle_i.
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  // Clock
  input wire logic clk_i,
  // Pulse request
  input wire logic idle_i,
  input wire logic go_i,
  input wire logic [7:0] width_i,
  // Pin
  output logic pin_o
);
  logic [7:0] left = 8'h00;
  // Level away from idle, so every pulse has two edges
  assign pin_o = idle_i ^ (left != 8'h00);
  always @(posedge clk_i) begin
    if (go_i) begin
      left <= width_i;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> test/event_timer_16bit_sva.sv
// Checker for the event timer, seeing its ports only.
// Assumes the strobe register port on one clock domain.
`timescale 1ns/1ps
`default_nettype none
module event_timer_16bit_sva (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Register port, pin, interrupt
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic timer_pin_i,
  input wire logic irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [7:0] ctrl;
  logic [7:0] lval;
  logic en;
  logic lok;
  logic rdl;
  // Run bit may self-clear in pulse mode, so stale run only weakens checks
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl <= 8'h00;
      lval <= 8'h00;
      en <= 1'b0;
      lok <= 1'b0;
      rdl <= 1'b0;
    end else begin
      rdl <= rd_i && addr_i == 2'h0;
      if (wr_i && addr_i == 2'h2) ctrl <= wdata_i;
      if (wr_i && addr_i == 2'h3) en <= wdata_i[0];
      if (rdl) begin
        lok <= 1'b1;
        lval <= rdata_o;
      end
      if (wr_i || (rd_i && addr_i == 2'h1)) lok <= 1'b0;
    end
  end
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its slot");
  chk_low_latch: assert property (rdl && lok |-> rdata_o == lval)
    else $error("low byte read not from latch");
  chk_stop_load: assert property ((wr_i && addr_i == 2'h1 && !ctrl[4]) ##1 (rd_i && addr_i == 2'h1)
    |=> rdata_o == $past(wdata_i, 2)) else $error("stopped counter missed load");
  chk_stop_hold: assert property ((rd_i && addr_i == 2'h1 && (!ctrl[4] || ctrl[7:6] == 2'h0))
    ##1 (rd_i && addr_i == 2'h1) |=> rdata_o == $past(rdata_o)) else $error("stopped counter moved");
  chk_irq_gated: assert property (irq_o |-> en)
    else $error("interrupt while disabled");
  chk_irq_mask: assert property (wr_i && addr_i == 2'h3 && !wdata_i[0] |=> ##1 !irq_o)
    else $error("interrupt not masked");
  chk_irq_readback: assert property (rd_i && addr_i == 2'h3
    |=> rdata_o[0] == $past(en) && rdata_o[7:2] == 6'h00) else $error("interrupt control readback");
  chk_ctrl_readback: assert property (rd_i && addr_i == 2'h2 && ctrl[7:6] != 2'h3
    |=> (rdata_o & 8'hD8) == ($past(ctrl) & 8'hD8)) else $error("control readback");
  cover property ((rd_i && addr_i == 2'h1) ##1 (rd_i && addr_i == 2'h0));
  cover property ($rose(irq_o));
  cover property ($fell(timer_pin_i));
endmodule
bind event_timer_16bit event_timer_16bit_sva event_timer_16bit_sva_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_pin_i(timer_pin_i),
  .irq_o(irq_o));
`default_nettype wire

// >>> test/tb.sv
// Testbench for the event timer: register port, counting modes, pulse measurement.
// Assumes the pin source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import event_timer_pkg::*;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  bus_req_type req = '0;
  logic [7:0] rdata_o, d, v, u, width = 8'h00;
  logic irq_o, pin, idle = 1'b0, go = 1'b0;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  // Wdata holds the expected value on read rows
  bus_req_type rows [9] = '{'{2'h2, 8'h00, 1'b1, 1'b0}, '{2'h0, 8'h34, 1'b1, 1'b0}, '{2'h1, 8'h12, 1'b1, 1'b0},
    '{2'h1, 8'h12, 1'b0, 1'b1}, '{2'h0, 8'h34, 1'b0, 1'b1}, '{2'h3, 8'h01, 1'b1, 1'b0},
    '{2'h3, 8'h01, 1'b0, 1'b1}, '{2'h2, 8'h50, 1'b1, 1'b0}, '{2'h2, 8'h50, 1'b0, 1'b1}};
  always #5 core_clk_i = ~core_clk_i;
  event_timer_16bit event_timer_16bit_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(req.addr),
    .wdata_i(req.wdata), .wr_i(req.wr), .rd_i(req.rd), .rdata_o(rdata_o), .timer_pin_i(pin), .irq_o(irq_o));
  pin_source pin_source_i (.clk_i(core_clk_i), .idle_i(idle), .go_i(go), .width_i(width), .pin_o(pin));
  task chk(input logic [7:0] s, input logic [7:0] e, input string what);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task op(input bus_req_type r);
    req <= r;
    @(posedge core_clk_i);
    req <= '0;
    #1 d = rdata_o;
  endtask
  task w(input logic [1:0] a, input logic [7:0] x);
    op('{a, x, 1'b1, 1'b0});
  endtask
  task rd(input logic [1:0] a);
    op('{a, 8'h00, 1'b0, 1'b1});
  endtask
  // High then low, so both halves come from one moment
  task rc;
    rd(2'h1);
    v = d;
    rd(2'h0);
  endtask
  task pulse(input logic [7:0] wd);
    width <= wd;
    go <= 1'b1;
    @(posedge core_clk_i);
    go <= 1'b0;
    repeat (wd + 8) @(posedge core_clk_i);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up;
    end
  end
  initial begin
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    @(posedge core_clk_i);
    foreach (rows[i]) begin
      op(rows[i]);
      if (rows[i].rd) chk(d, rows[i].wdata, "row");
    end
    repeat (3) pulse(8'h04);
    rc;
    chk(d, 8'h37, "rising count");
    w(2'h2, 8'h58);
    idle <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    pulse(8'h04);
    rc;
    chk(d, 8'h38, "falling count");
    idle <= 1'b0;
    w(2'h2, 8'h00);
    w(2'h0, 8'hF0);
    w(2'h1, 8'hFF);
    w(2'h2, 8'h10);
    repeat (40) @(posedge core_clk_i);
    rd(2'h1);
    rc;
    rd(2'h0);
    chk(d, 8'hF0, "hold mode");
    w(2'h2, 8'h90);
    w(2'h0, 8'h00);
    w(2'h1, 8'h80);
    repeat (20) @(posedge core_clk_i);
    rc;
    chk(v, 8'hFF, "preload while running");
    n = 0;
    while (irq_o !== 1'b1 && n < 200) begin
      @(posedge core_clk_i);
      n++;
    end
    chk({7'h00, irq_o}, 8'h01, "overflow irq");
    rc;
    chk(v, 8'h80, "reload");
    u = d;
    repeat (38) @(posedge core_clk_i);
    rc;
    chk(d - u, 8'h0A, "tick rate");
    w(2'h3, 8'h03);
    repeat (2) @(posedge core_clk_i);
    chk({7'h00, irq_o}, 8'h00, "irq clear");
    w(2'h3, 8'h00);
    w(2'h2, 8'h00);
    w(2'h0, 8'h00);
    w(2'h1, 8'h00);
    w(2'h2, 8'hD8);
    pulse(8'h50);
    rc;
    u = d;
    chk(v, 8'h00, "pulse width high");
    chk({7'h00, (d >= 8'h13 && d <= 8'h15)}, 8'h01, "pulse width");
    rd(2'h2);
    chk(d & 8'h10, 8'h00, "run self clear");
    pulse(8'h50);
    rc;
    chk(d, u, "rearm needed");
    rstn_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    @(posedge core_clk_i);
    rd(2'h2);
    chk(d, 8'h00, "control after reset");
    chk({7'h00, irq_o}, 8'h00, "irq after reset");
    wrap_up;
  end
endmodule
`default_nettype wire
